/* File: include/pcp_pkg.sv */
// register map, field layout and reset values of the pwm clock prescale and alignment block
package pcp_pkg;
  // register indices; byte address on the bus is four times the index
  localparam logic [7:0] PCP_IDX_CTRL = 8'h60;
  localparam logic [7:0] PCP_IDX_PRESCALE = 8'h61;
  localparam logic [7:0] PCP_IDX_SCALE_A = 8'h62;
  localparam logic [7:0] PCP_IDX_SCALE_B = 8'h63;
  localparam logic [7:0] PCP_IDX_PERIOD0 = 8'h64;
  localparam logic [7:0] PCP_IDX_PERIOD1 = 8'h65;
  localparam logic [7:0] PCP_IDX_DUTY0 = 8'h66;
  localparam logic [7:0] PCP_IDX_DUTY1 = 8'h67;
  localparam logic [7:0] PCP_IDX_COUNT0 = 8'h68;
  localparam logic [7:0] PCP_IDX_COUNT1 = 8'h69;

  // pwm_prescale_select fields
  localparam int PCP_CODE_W = 3;
  localparam int PCP_CLK_A_LSB = 0;
  localparam int PCP_CLK_B_LSB = 4;
  localparam logic [7:0] PCP_PRESCALE_MASK = 8'h77;
  localparam logic [7:0] PCP_PRESCALE_RST = 8'h00;

  // control register fields
  localparam int PCP_CTRL_EN_LSB = 0;
  localparam int PCP_CTRL_CHOICE_LSB = 2;
  localparam int PCP_CTRL_ALIGN_LSB = 4;
  localparam logic [7:0] PCP_CTRL_MASK = 8'h3F;
  localparam logic [7:0] PCP_CTRL_RST = 8'h00;

  localparam logic [7:0] PCP_SCALE_RST = 8'h00;
  localparam logic [7:0] PCP_PERIOD_RST = 8'hFF;
  localparam logic [7:0] PCP_DUTY_RST = 8'h00;

  localparam int PCP_CHANNELS = 2;
endpackage : pcp_pkg

/* File: logic/pcp_prescaler.sv */
// binary prescaler: one-cycle tick at the clock divided by two to the code
`timescale 1ns/1ns
`default_nettype none
module pcp_prescaler #(
  parameter int CODE_W = 3
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [CODE_W-1:0] i_code,
  output logic o_tick
);
  localparam int CNT_W = (1 << CODE_W) - 1;

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] code_mask;

  if (CODE_W < 1 || CODE_W > 4) begin : g_check
    $error("pcp_prescaler: CODE_W must lie between 1 and 4");
  end

  // a code change takes effect at once, so the current period may be cut or stretched
  assign code_mask = CNT_W'(({{CNT_W{1'b0}}, 1'b1} << i_code) - 1'b1);
  assign o_tick = &(count | ~code_mask);

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end
endmodule : pcp_prescaler
`default_nettype wire

/* File: logic/pcp_top.sv */
// two-channel pwm with clock prescale, clock choice and alignment, apb register access
// Overview of operation
// - channel clock-choice bits are writable at any time; pulses may stretch or truncate.
// - each channel selects one of two clock sources with its clock-choice bit.
// - alignment bit one makes that channel's output center aligned.
// - alignment bit zero makes that channel's output left aligned.
// - clock A and clock B prescalers are set independently.
// - prescale bits 6 to 4 set the rate of clock B, used by channel 1.
// - prescale bits 2 to 0 set the rate of clock A, used by channel 0.
// - clock B is interface clock divided by two to the code, up to 128.
// - clock A uses the same encoding from its own code, up to 128.
// - both prescale fields are writable at any time; pulses may stretch or truncate.
// - channel 0 picks clock A or scaled_clock_a; channel 1 clock B or scaled_clock_b.
`timescale 1ns/1ns
`default_nettype none
module pcp_top
  import pcp_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [PCP_CHANNELS-1:0] o_pwm
);
  if (ADDR_W < 10 || ADDR_W > 32) begin : g_check
    $error("pcp_top: ADDR_W must lie between 10 and 32");
  end

  // bus decode
  logic [7:0] reg_index;
  logic upper_zero;
  logic hit_ctrl;
  logic hit_prescale;
  logic hit_scale_a;
  logic hit_scale_b;
  logic hit_period0;
  logic hit_period1;
  logic hit_duty0;
  logic hit_duty1;
  logic hit_count0;
  logic hit_count1;
  logic mapped;
  logic setup_phase;
  logic access_phase;
  logic write_low_byte;

  assign reg_index = i_paddr[9:2];
  assign upper_zero = (ADDR_W == 10) ? 1'b1 : (i_paddr >> 10) == '0;
  assign hit_ctrl = upper_zero && i_paddr[1:0] == 2'h0 && reg_index == PCP_IDX_CTRL;
  assign hit_prescale = upper_zero && i_paddr[1:0] == 2'h0 && reg_index == PCP_IDX_PRESCALE;
  assign hit_scale_a = upper_zero && i_paddr[1:0] == 2'h0 && reg_index == PCP_IDX_SCALE_A;
  assign hit_scale_b = upper_zero && i_paddr[1:0] == 2'h0 && reg_index == PCP_IDX_SCALE_B;
  assign hit_period0 = upper_zero && i_paddr[1:0] == 2'h0 && reg_index == PCP_IDX_PERIOD0;
  assign hit_period1 = upper_zero && i_paddr[1:0] == 2'h0 && reg_index == PCP_IDX_PERIOD1;
  assign hit_duty0 = upper_zero && i_paddr[1:0] == 2'h0 && reg_index == PCP_IDX_DUTY0;
  assign hit_duty1 = upper_zero && i_paddr[1:0] == 2'h0 && reg_index == PCP_IDX_DUTY1;
  assign hit_count0 = upper_zero && i_paddr[1:0] == 2'h0 && reg_index == PCP_IDX_COUNT0;
  assign hit_count1 = upper_zero && i_paddr[1:0] == 2'h0 && reg_index == PCP_IDX_COUNT1;
  assign mapped = hit_ctrl | hit_prescale | hit_scale_a | hit_scale_b | hit_period0 |
                  hit_period1 | hit_duty0 | hit_duty1 | hit_count0 | hit_count1;

  assign setup_phase = i_psel && !i_penable;
  assign access_phase = i_psel && i_penable;
  // every access finishes in its first access cycle
  assign o_pready = access_phase;
  assign o_pslverr = access_phase && !mapped;
  // counters are read-only; a write there is ignored and not flagged
  assign write_low_byte = access_phase && i_pwrite && i_pstrb[0];

  // registers
  logic [7:0] ctrl;
  logic [7:0] prescale;
  logic [7:0] scale [PCP_CHANNELS];
  logic [7:0] period [PCP_CHANNELS];
  logic [7:0] duty [PCP_CHANNELS];
  logic [7:0] chan_count [PCP_CHANNELS];
  logic [PCP_CHANNELS-1:0] scale_written;
  logic [31:0] next_rdata;

  assign scale_written[0] = write_low_byte && hit_scale_a;
  assign scale_written[1] = write_low_byte && hit_scale_b;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      ctrl <= PCP_CTRL_RST;
      prescale <= PCP_PRESCALE_RST;
    end else begin
      if (write_low_byte && hit_ctrl) begin
        ctrl <= i_pwdata[7:0] & PCP_CTRL_MASK;
      end
      if (write_low_byte && hit_prescale) begin
        prescale <= i_pwdata[7:0] & PCP_PRESCALE_MASK;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      scale[0] <= PCP_SCALE_RST;
      scale[1] <= PCP_SCALE_RST;
      period[0] <= PCP_PERIOD_RST;
      period[1] <= PCP_PERIOD_RST;
      duty[0] <= PCP_DUTY_RST;
      duty[1] <= PCP_DUTY_RST;
    end else begin
      if (scale_written[0]) begin
        scale[0] <= i_pwdata[7:0];
      end
      if (scale_written[1]) begin
        scale[1] <= i_pwdata[7:0];
      end
      if (write_low_byte && hit_period0) begin
        period[0] <= i_pwdata[7:0];
      end
      if (write_low_byte && hit_period1) begin
        period[1] <= i_pwdata[7:0];
      end
      if (write_low_byte && hit_duty0) begin
        duty[0] <= i_pwdata[7:0];
      end
      if (write_low_byte && hit_duty1) begin
        duty[1] <= i_pwdata[7:0];
      end
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit_ctrl) begin
      next_rdata[7:0] = ctrl;
    end else if (hit_prescale) begin
      next_rdata[7:0] = prescale & PCP_PRESCALE_MASK;
    end else if (hit_scale_a) begin
      next_rdata[7:0] = scale[0];
    end else if (hit_scale_b) begin
      next_rdata[7:0] = scale[1];
    end else if (hit_period0) begin
      next_rdata[7:0] = period[0];
    end else if (hit_period1) begin
      next_rdata[7:0] = period[1];
    end else if (hit_duty0) begin
      next_rdata[7:0] = duty[0];
    end else if (hit_duty1) begin
      next_rdata[7:0] = duty[1];
    end else if (hit_count0) begin
      next_rdata[7:0] = chan_count[0];
    end else if (hit_count1) begin
      next_rdata[7:0] = chan_count[1];
    end
  end

  // read data is captured in the setup cycle so it leaves a flip-flop
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_prdata <= 32'h0000_0000;
    end else if (setup_phase) begin
      o_prdata <= next_rdata;
    end
  end

  // prescaled clocks A and B as enable ticks
  logic [PCP_CHANNELS-1:0] base_tick;

  pcp_prescaler #(
    .CODE_W(PCP_CODE_W)
  ) u_prescale_a (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_code(prescale[PCP_CLK_A_LSB +: PCP_CODE_W]),
    .o_tick(base_tick[0])
  );

  pcp_prescaler #(
    .CODE_W(PCP_CODE_W)
  ) u_prescale_b (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_code(prescale[PCP_CLK_B_LSB +: PCP_CODE_W]),
    .o_tick(base_tick[1])
  );

  // per channel: scaled clock, clock choice and counter
  for (genvar ch = 0; ch < PCP_CHANNELS; ch++) begin : g_chan
    logic [7:0] scale_count;
    logic scale_half;
    logic scale_wrap;
    logic scaled_tick;
    logic chan_tick;
    logic chan_enable;
    logic center_align;
    logic count_down;
    logic [7:0] count;
    logic at_top;
    logic at_bottom;
    logic next_down;
    logic [7:0] next_count;

    // zero in the scale register stands for 256
    assign scale_wrap = base_tick[ch] && scale_count == 8'h01;
    // scaled clock: a tick every second wrap of the scale counter
    assign scaled_tick = scale_wrap && scale_half;

    always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
        scale_count <= 8'h00;
        scale_half <= 1'b0;
      end else if (scale_written[ch]) begin
        scale_count <= i_pwdata[7:0];
        scale_half <= 1'b0;
      end else if (base_tick[ch]) begin
        scale_count <= scale_wrap ? scale[ch] : scale_count - 8'h01;
        scale_half <= scale_wrap ? !scale_half : scale_half;
      end
    end

    // channel 0 sees clock A or scaled_clock_a, channel 1 clock B or scaled_clock_b
    assign chan_tick = ctrl[PCP_CTRL_CHOICE_LSB + ch] ? scaled_tick : base_tick[ch];
    assign chan_enable = ctrl[PCP_CTRL_EN_LSB + ch];
    // no shadowing: an alignment change on a running channel takes effect at once
    assign center_align = ctrl[PCP_CTRL_ALIGN_LSB + ch];
    assign at_top = count >= period[ch] - 8'h01;
    assign at_bottom = count == 8'h00;

    always_comb begin
      next_down = count_down;
      next_count = count;
      if (center_align) begin
        // up to the period, then back down to zero
        if (!count_down && count >= period[ch]) begin
          next_down = 1'b1;
          next_count = (period[ch] == 8'h00) ? 8'h00 : count - 8'h01;
        end else if (count_down && at_bottom) begin
          next_down = 1'b0;
          next_count = 8'h01;
        end else begin
          next_count = count_down ? count - 8'h01 : count + 8'h01;
        end
      end else begin
        next_down = 1'b0;
        next_count = (at_top || count_down) ? 8'h00 : count + 8'h01;
      end
    end

    always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
        count <= 8'h00;
        count_down <= 1'b0;
      end else if (!chan_enable) begin
        count <= 8'h00;
        count_down <= 1'b0;
      end else if (chan_tick) begin
        count <= next_count;
        count_down <= next_down;
      end
    end

    // high while the counter is under the duty value, in both alignments
    always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
        o_pwm[ch] <= 1'b0;
      end else begin
        o_pwm[ch] <= chan_enable && (count < duty[ch]);
      end
    end

    assign chan_count[ch] = count;
  end
endmodule : pcp_top
`default_nettype wire

/* File: verification/pcp_checker.sv */
// concurrent checks on the apb port and pwm outputs of the prescale block
`timescale 1ns/1ns
`default_nettype none
module pcp_checker
  import pcp_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [PCP_CHANNELS-1:0] o_pwm
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  logic [7:0] prescale;
  logic [1:0] enable;
  wire access = i_psel && i_penable;
  wire wr_ok = access && i_pwrite && i_pstrb[0];
  wire at_pre = i_paddr == ADDR_W'({PCP_IDX_PRESCALE, 2'b00});
  wire at_ctrl = i_paddr == ADDR_W'({PCP_IDX_CTRL, 2'b00});
  wire mapped = i_paddr[1:0] == 2'b00 && i_paddr >= ADDR_W'({PCP_IDX_CTRL, 2'b00})
    && i_paddr <= ADDR_W'({PCP_IDX_COUNT1, 2'b00});
  // shadow copies so readback is tied to the write that caused it
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      prescale <= PCP_PRESCALE_RST;
      enable <= 2'b00;
    end else if (wr_ok && at_pre) begin
      prescale <= i_pwdata[7:0] & PCP_PRESCALE_MASK;
    end else if (wr_ok && at_ctrl) begin
      enable <= i_pwdata[1:0];
    end
  end
  a_ready_access: assert property (access |-> o_pready)
    else $error("no ready in access phase");
  a_err_unmapped: assert property (access && !mapped |-> o_pslverr)
    else $error("no error on unmapped access");
  a_err_mapped: assert property (access && mapped |-> !o_pslverr)
    else $error("error on mapped access");
  a_prescale_readback: assert property (access && !i_pwrite && at_pre |-> o_prdata == {24'h0, prescale})
    else $error("prescale readback differs");
  a_read_upper_zero: assert property (access && !i_pwrite |-> o_prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_pwm_reset_low: assert property ($rose(i_rst_n) |-> o_pwm == '0)
    else $error("pwm high after reset");
  a_pwm_off_ch0: assert property (!enable[0] [*3] |-> !o_pwm[0])
    else $error("channel 0 output while disabled");
  a_pwm_off_ch1: assert property (!enable[1] [*3] |-> !o_pwm[1])
    else $error("channel 1 output while disabled");
  c_prescale_write: cover property (wr_ok && at_pre);
  c_unmapped: cover property (access && !mapped);
  c_pwm1_rise: cover property ($rose(o_pwm[1]));
endmodule : pcp_checker
bind pcp_top pcp_checker #(.ADDR_W(ADDR_W)) u_chk (.i_clock(i_clock), .i_rst_n(i_rst_n),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_pwm(o_pwm));
`default_nettype wire

/* File: verification/pwm_clock_prescale_align_bench.sv */
// self-checking bench for the pwm clock prescale and alignment block
`timescale 1ns/1ns
`default_nettype none
module pwm_clock_prescale_align_bench;
  import pcp_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0;
  logic [3:0] i_pstrb = 4'hF;
  logic [31:0] o_prdata;
  logic o_pready;
  logic o_pslverr;
  logic [1:0] o_pwm;
  int err_total = 0;
  int compares = 0;
  int hi_seen = 0;
  int per_seen = 0;
  always #10 i_clock = ~i_clock;
  pcp_top DUT (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_pwm(o_pwm));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up();
    $display("mismatches %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  // one edge of idle first, so release and next setup never share a time step
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge i_clock);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= 12'({idx, 2'b00});
    i_pwdata <= {24'h0, wd};
    @(posedge i_clock);
    i_penable <= 1'b1;
    // no wait count assumed here; a hang is left to the watchdog
    do @(posedge i_clock); while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb
  task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask : wreg
  task automatic rchk(input logic [7:0] idx, input logic [31:0] exp, input logic exp_err);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 8'h00, r, e);
    check(r, exp);
    check({31'h0, e}, {31'h0, exp_err});
  endtask : rchk
  task automatic step(inout int n);
    @(posedge i_clock);
    n++;
  endtask : step
  // first high phase after enable depends on prescaler phase, so skip it whole
  task automatic measure(input int ch, output int hi, output int per);
    int n;
    int rise;
    n = 0;
    while (o_pwm[ch] !== 1'b1 && n < 5000) step(n);
    while (o_pwm[ch] === 1'b1 && n < 5000) step(n);
    while (o_pwm[ch] !== 1'b1 && n < 5000) step(n);
    rise = n;
    while (o_pwm[ch] === 1'b1 && n < 5000) step(n);
    hi = n - rise;
    while (o_pwm[ch] !== 1'b1 && n < 5000) step(n);
    per = n - rise;
    if (n >= 5000) err_total++;
  endtask : measure
  task automatic run(input int ch, input logic [2:0] code, input logic [1:0] mode,
                     input int hi_exp, input int per_exp);
    int hi;
    int per;
    wreg(PCP_IDX_CTRL, 8'h00);
    wreg(PCP_IDX_PRESCALE, ch != 0 ? {1'b0, code, 1'b0, ~code} : {1'b0, ~code, 1'b0, code});
    wreg(PCP_IDX_SCALE_A, 8'h01);
    wreg(PCP_IDX_SCALE_B, 8'h01);
    wreg(PCP_IDX_PERIOD0 + 8'(ch), 8'h04);
    wreg(PCP_IDX_DUTY0 + 8'(ch), 8'h02);
    wreg(PCP_IDX_CTRL, 8'((1 << ch) | (mode[0] << (2 + ch)) | (mode[1] << (4 + ch))));
    measure(ch, hi, per);
    if (mode[1] == 1'b0) check(hi, hi_exp);
    check(per, per_exp);
  endtask : run
  initial begin
    repeat (8) @(posedge i_clock);
    i_rst_n <= 1'b1;
    rchk(PCP_IDX_PRESCALE, 32'h0, 1'b0);
    wreg(PCP_IDX_PRESCALE, 8'hFF);
    rchk(PCP_IDX_PRESCALE, 32'h77, 1'b0);
    wreg(PCP_IDX_PRESCALE, 8'h50);
    rchk(PCP_IDX_PRESCALE, 32'h50, 1'b0);
    wreg(PCP_IDX_PRESCALE, 8'h03);
    rchk(PCP_IDX_PRESCALE, 32'h03, 1'b0);
    rchk(8'h7F, 32'h0, 1'b1);
    // low byte strobe off: the write must not land
    i_pstrb <= 4'hE;
    wreg(PCP_IDX_PRESCALE, 8'h12);
    i_pstrb <= 4'hF;
    rchk(PCP_IDX_PRESCALE, 32'h03, 1'b0);
    for (int ch = 0; ch < 2; ch++) begin
      for (int c = 0; c < 8; c++) begin
        run(ch, 3'(c), 2'b00, 2 << c, 4 << c);
      end
    end
    run(0, 3'd1, 2'b10, 0, 16);
    run(1, 3'd0, 2'b10, 0, 8);
    run(0, 3'd0, 2'b01, 4, 8);
    run(1, 3'd1, 2'b01, 8, 16);
    // live rate and clock changes while channel 0 runs, ending scaled at code 1
    run(0, 3'd0, 2'b00, 2, 4);
    wreg(PCP_IDX_PRESCALE, 8'h01);
    wreg(PCP_IDX_CTRL, 8'h05);
    rchk(PCP_IDX_CTRL, 32'h05, 1'b0);
    measure(0, hi_seen, per_seen);
    check(hi_seen, 8);
    check(per_seen, 16);
    run(0, 3'd1, 2'b01, 8, 16);
    wrap_up();
  end
  initial begin
    // roughly eight times the longest expected run
    #800000;
    err_total++;
    wrap_up();
  end
endmodule : pwm_clock_prescale_align_bench
`default_nettype wire
